// ---- pgh_port_regs.sv ----
`timescale 1ns/1ps
`include "pgh_params.svh"
module pgh_port_regs
   import pgh_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   input  wire logic [7:0]  port_a_pin,
   input  wire logic [7:0]  port_b_pin,
   input  wire logic [7:0]  port_c_pin,
   input  wire pgh_pinctl_s port_a_pin_control,
   input  wire pgh_pinctl_s port_b_pin_control,
   input  wire pgh_pinctl_s port_c_pin_control,
   output      logic        port_b_pin7_out,
   output      logic        port_b_pin7_oe,
   output      pgh_pad_s    port_c_pad,
   output      logic [7:0]  port_a_pullup_en,
   output      logic [7:0]  port_b_pullup_en,
   output      logic [7:0]  port_c_pullup_en
);

   localparam logic [31:0] IDX_A = `PGH_IDX_PORT_A;
   localparam logic [31:0] IDX_B = `PGH_IDX_PORT_B;
   localparam logic [31:0] IDX_C = `PGH_IDX_PORT_C;
   localparam int          BB    = `PGH_BIDIR_BIT;
   localparam int          IB    = `PGH_FSEL_INPUT_BIT;

   logic [2:0][7:0] pin_meta_reg;
   logic [2:0][7:0] pin_sync_reg;
   logic            bidir_reg;
   logic [7:0]      port_c_reg;
   logic [7:0]      a_in_mask;
   logic [7:0]      b_in_mask;
   logic [7:0]      c_in_mask;
   logic [7:0]      c_out_mask;
   logic [7:0]      a_rd;
   logic [7:0]      b_rd;
   logic [7:0]      c_rd;
   logic [7:0]      rd_byte;
   logic            hit_a;
   logic            hit_b;
   logic            hit_c;
   logic            hit_any;
   logic            acc_start;
   logic            wr_done;
   logic            b7_out_sel;

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers, resampled every clock

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
      end else begin
         pin_meta_reg <= {port_c_pin, port_b_pin, port_a_pin};
         pin_sync_reg <= pin_meta_reg;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// per-bit read selection

   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_bit
         assign a_in_mask[i]  = port_a_pin_control.fsel[i][IB];
         assign b_in_mask[i]  = port_b_pin_control.fsel[i][IB];
         assign c_in_mask[i]  = port_c_pin_control.fsel[i][IB];
         assign c_out_mask[i] = port_c_pin_control.fsel[i] == `PGH_FSEL_OUT;
         // first port non-input bits read zero, third port non-input bits read the stored register
         assign a_rd[i] = a_in_mask[i] & pin_sync_reg[0][i];
         assign c_rd[i] = c_in_mask[i] ? pin_sync_reg[2][i] : port_c_reg[i];
         if (i == BB) begin : g_bidir
            // stored bit unless input selected
            assign b_rd[i] = b_in_mask[i] ? pin_sync_reg[1][i] : bidir_reg;
         end else begin : g_in
            assign b_rd[i] = b_in_mask[i] & pin_sync_reg[1][i];
         end
      end
   endgenerate

   assign b7_out_sel = port_b_pin_control.fsel[BB] == `PGH_FSEL_OUT;

////////////////////////////////////////////////////////////////////////////////
// address decode, physical and untranslated aliases share the index bits

   always_comb begin
      hit_a = paddr[`PGH_IDX_CMP_MSB+2:2] == IDX_A[`PGH_IDX_CMP_MSB:0];
      hit_b = paddr[`PGH_IDX_CMP_MSB+2:2] == IDX_B[`PGH_IDX_CMP_MSB:0];
      hit_c = paddr[`PGH_IDX_CMP_MSB+2:2] == IDX_C[`PGH_IDX_CMP_MSB:0];
      hit_any = (paddr[1:0] == 2'h0) & (hit_a | hit_b | hit_c);
      rd_byte = 8'h00;
      if (hit_a) begin
         rd_byte = a_rd;
      end else if (hit_b) begin
         rd_byte = b_rd;
      end else if (hit_c) begin
         rd_byte = c_rd;
      end
   end

   assign acc_start = psel & penable & ~pready;
   assign wr_done   = psel & penable & pready & pwrite & pstrb[0] & hit_any & ~pslverr;

////////////////////////////////////////////////////////////////////////////////
// apb answer, one wait state

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= `PGH_RST_RDATA;
      end else begin
         pready  <= acc_start;
         pslverr <= acc_start & ~hit_any;
         if (acc_start & ~pwrite & hit_any) begin
            prdata <= {24'h00_0000, rd_byte};
         end else begin
            prdata <= `PGH_RST_RDATA;
         end
      end
   end

////////////////////////////////////////////////////////////////////////////////
// data registers, first port has none and ignores writes

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bidir_reg <= `PGH_RST_BIDIR;
      end else if (wr_done & hit_b) begin
         bidir_reg <= pwdata[BB];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_c_reg <= `PGH_RST_PORT_C;
      end else if (wr_done & hit_c) begin
         port_c_reg <= pwdata[7:0];
      end
   end

////////////////////////////////////////////////////////////////////////////////
// pad drive and pull-ups

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_b_pin7_out <= `PGH_RST_BIDIR;
         port_b_pin7_oe  <= 1'b0;
         port_c_pad      <= '0;
      end else begin
         port_b_pin7_out <= bidir_reg;
         port_b_pin7_oe  <= b7_out_sel;
         port_c_pad.dout <= port_c_reg;
         port_c_pad.oe   <= c_out_mask;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_a_pullup_en <= `PGH_RST_PULLUP;
         port_b_pullup_en <= `PGH_RST_PULLUP;
         port_c_pullup_en <= `PGH_RST_PULLUP;
      end else begin
         port_a_pullup_en <= port_a_pin_control.pullup_en;
         port_b_pullup_en <= port_b_pin_control.pullup_en;
         port_c_pullup_en <= port_c_pin_control.pullup_en;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// checks

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_read(hit);
      acc_start && !pwrite && hit && (paddr[1:0] == 2'h0);
   endsequence

   sequence s_write(hit);
      psel && penable && pready && pwrite && pstrb[0] && hit && !pslverr;
   endsequence

   sequence s_rst_done;
      $rose(presetn);
   endsequence

   chk_apb_answer: assert property (
      acc_start |=> pready ##1 !pready)
      else $error("apb answer not one wait state");

   chk_unmapped_err: assert property (
      acc_start && !hit_any |=> pready && pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not flagged");

   chk_a_masked: assert property (
      s_read(hit_a) |=> (prdata[7:0] & ~$past(a_in_mask)) == 8'h00 && prdata[31:8] == 24'h0)
      else $error("first port non-input bit not zero");

   chk_a_pin: assert property (
      s_read(hit_a) |=> prdata[7:0] == ($past(pin_sync_reg[0]) & $past(a_in_mask)))
      else $error("first port read differs from pins");

   chk_b_low_bits: assert property (
      s_read(hit_b) |=> prdata[6:0] == ($past(pin_sync_reg[1][6:0]) & $past(b_in_mask[6:0])))
      else $error("second port low bits wrong");

   chk_b7_stored_read: assert property (
      s_read(hit_b && !b_in_mask[BB]) |=> prdata[BB] == $past(bidir_reg))
      else $error("bit 7 read not stored value");

   chk_b7_write: assert property (
      s_write(hit_b) |=> bidir_reg == $past(pwdata[BB]))
      else $error("bit 7 write lost");

   chk_b7_hold: assert property (
      !(psel && penable && pready && pwrite && pstrb[0] && hit_b && !pslverr)
         |=> $stable(bidir_reg))
      else $error("bit 7 changed without write");

   chk_b7_drive: assert property (
      b7_out_sel ##1 b7_out_sel |-> port_b_pin7_oe && port_b_pin7_out == $past(bidir_reg))
      else $error("bit 7 not driven in output mode");

   chk_b7_no_drive: assert property (
      !b7_out_sel |=> !port_b_pin7_oe)
      else $error("bit 7 driven outside output mode");

   chk_c_write: assert property (
      s_write(hit_c) |=> port_c_reg == $past(pwdata[7:0]) ##1 port_c_pad.dout == $past(port_c_reg))
      else $error("third port write not stored or driven");

   chk_pin_sync: assert property (
      $past(presetn) && $past(presetn, 2)
         |-> pin_sync_reg == $past({port_c_pin, port_b_pin, port_a_pin}, 2))
      else $error("pin synchroniser latency wrong");

   chk_rd_upper: assert property (
      acc_start && !pwrite |=> prdata[31:8] == 24'h00_0000)
      else $error("read data upper bits not zero");

   chk_idle_rdata: assert property (
      !acc_start |=> prdata == 32'h0000_0000)
      else $error("read data not cleared outside answer");

   chk_pready_pulse: assert property (
      pready |=> !pready)
      else $error("pready held over one cycle");

   chk_err_with_ready: assert property (
      pslverr |-> pready)
      else $error("error flagged without ready");

   chk_err_no_write: assert property (
      acc_start && !hit_any |=> ##1 $stable(bidir_reg) && $stable(port_c_reg))
      else $error("refused access changed a register");

   chk_no_strobe: assert property (
      acc_start && pwrite && !pstrb[0] |=> ##1 $stable(bidir_reg) && $stable(port_c_reg))
      else $error("write without byte strobe stored");

   chk_b7_reset: assert property (
      s_rst_done |-> bidir_reg == `PGH_RST_BIDIR)
      else $error("bit 7 not cleared by reset");

   chk_c_reset: assert property (
      s_rst_done |-> port_c_reg == `PGH_RST_PORT_C)
      else $error("third port not cleared by reset");

   chk_pullup_reset: assert property (
      s_rst_done |-> port_a_pullup_en == `PGH_RST_PULLUP && port_b_pullup_en == `PGH_RST_PULLUP
         && port_c_pullup_en == `PGH_RST_PULLUP)
      else $error("pull-ups not on after reset");

   chk_pullup_follow: assert property (
      presetn |=> port_a_pullup_en == $past(port_a_pin_control.pullup_en)
         && port_b_pullup_en == $past(port_b_pin_control.pullup_en)
         && port_c_pullup_en == $past(port_c_pin_control.pullup_en))
      else $error("pull-up enable does not follow controller");

   chk_b7_pin_read: assert property (
      s_read(hit_b && b_in_mask[BB]) |=> prdata[BB] == $past(pin_sync_reg[1][BB]))
      else $error("bit 7 input read not pin level");

   chk_c_read: assert property (
      s_read(hit_c) |=> prdata[7:0] == (($past(pin_sync_reg[2]) & $past(c_in_mask))
         | ($past(port_c_reg) & ~$past(c_in_mask))))
      else $error("third port read wrong");

   chk_c_drive: assert property (
      presetn |=> port_c_pad.oe == $past(c_out_mask) && port_c_pad.dout == $past(port_c_reg))
      else $error("third port pads not driven from register");

   chk_b7_oe_lag: assert property (
      presetn |=> port_b_pin7_oe == $past(b7_out_sel))
      else $error("bit 7 enable does not follow select");

endmodule : pgh_port_regs

// ---- pgh_params.svh ----
`ifndef PGH_PARAMS_SVH
`define PGH_PARAMS_SVH
// Operation
// - first port register reads its eight pins
// - first port non-input bits read zero, writes ignored
// - input-mode bit returns present sampled pin level
// - first port defaults to input with pull-up
// - power-on reset leaves pins input with pull-up
// - every pin pull-up enable comes from controller
// - second port: bit 7 bidirectional, 6-0 inputs
// - second port bit 7 writable, bits 6-0 read-only
// - power-on reset clears second port bit 7
// - bit 7 holds value except reset or write
// - output select drives stored bit 7 onto pin
// - output or other select reads stored bit
// - non-output selects store write, pin untouched
// - second port bits 6-0 non-input read low
// - register word indexes and aliases, byte access
// - third port read/write register, reset zero

////////////////////////////////////////////////////////////////////////////////
// register indexes, byte address is four times the index
`define PGH_IDX_PORT_A      32'h0400_012C
`define PGH_IDX_PORT_B      32'h0400_012E
`define PGH_IDX_PORT_C      32'h0400_0130
// index bits compared, the rest select the address region
`define PGH_IDX_CMP_MSB     28

////////////////////////////////////////////////////////////////////////////////
// fields
`define PGH_BIDIR_BIT       7
`define PGH_FSEL_OUT        2'h1
`define PGH_FSEL_INPUT_BIT  1

////////////////////////////////////////////////////////////////////////////////
// reset values
`define PGH_RST_BIDIR       1'h0
`define PGH_RST_PORT_C      8'h00
`define PGH_RST_PULLUP      8'hFF
`define PGH_RST_RDATA       32'h0000_0000

`endif

// ---- pgh_pkg.sv ----
package pgh_pkg;

   typedef logic [1:0] pgh_fsel_t;

   // function selects and pull-up enables of one port
   typedef struct packed {
      pgh_fsel_t [7:0] fsel;
      logic      [7:0] pullup_en;
   } pgh_pinctl_s;

   // drive value and enable of one port's pads
   typedef struct packed {
      logic [7:0] dout;
      logic [7:0] oe;
   } pgh_pad_s;

endpackage : pgh_pkg

// ---- pgh_pin_model.sv ----
`timescale 1ns/1ps
module pgh_pin_model
   import pgh_pkg::*;
(
   input  wire logic       drv,
   input  wire logic [7:0] ext_a,
   input  wire logic [7:0] ext_b,
   input  wire logic [7:0] ext_c,
   input  wire logic [7:0] pu_a,
   input  wire logic [7:0] pu_b,
   input  wire logic [7:0] pu_c,
   input  wire logic       b7_out,
   input  wire logic       b7_oe,
   input  wire pgh_pad_s   pad_c,
   output      logic [7:0] pin_a,
   output      logic [7:0] pin_b,
   output      logic [7:0] pin_c
);
   logic [7:0] lvl_a;
   logic [7:0] lvl_b;
   logic [7:0] lvl_c;
   // released pads go to the pull-up, else to the inverse of the last value
   assign lvl_a = drv ? ext_a : (pu_a | ~ext_a);
   assign lvl_b = drv ? ext_b : (pu_b | ~ext_b);
   assign lvl_c = drv ? ext_c : (pu_c | ~ext_c);
   assign pin_a = lvl_a;
   assign pin_b = {b7_oe ? b7_out : lvl_b[7], lvl_b[6:0]};
   assign pin_c = (pad_c.oe & pad_c.dout) | (~pad_c.oe & lvl_c);
endmodule : pgh_pin_model

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top
   import pgh_pkg::*;
;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, drv = 1;
   logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
   logic [3:0]  pstrb = 4'h1;
   logic        pready, pslverr, b7_out, b7_oe, er;
   logic [7:0]  pu_a, pu_b, pu_c, pin_a, pin_b, pin_c;
   logic [7:0]  ext_a = 8'h00, ext_b = 8'h00, ext_c = 8'h00;
   pgh_pinctl_s ctl_a = {16'hAAAA, 8'hFF}, ctl_b = {16'hAAAA, 8'hFF};
   pgh_pinctl_s ctl_c = {16'h0000, 8'hFF};
   pgh_pad_s    pad_c;
   int          errors = 0, total_checks = 0, cyc = 0;
   // uncached region byte addresses
   localparam logic [31:0] AD_A = 32'h9000_04B0, AD_B = 32'h9000_04B8;
   localparam logic [31:0] AD_C = 32'h9000_04C0;

   always #20 pclk = ~pclk;

   pgh_port_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .port_a_pin(pin_a), .port_b_pin(pin_b),
      .port_c_pin(pin_c), .port_a_pin_control(ctl_a), .port_b_pin_control(ctl_b),
      .port_c_pin_control(ctl_c), .port_b_pin7_out(b7_out), .port_b_pin7_oe(b7_oe),
      .port_c_pad(pad_c), .port_a_pullup_en(pu_a), .port_b_pullup_en(pu_b),
      .port_c_pullup_en(pu_c));

   pgh_pin_model pins (.drv(drv), .ext_a(ext_a), .ext_b(ext_b), .ext_c(ext_c),
      .pu_a(pu_a), .pu_b(pu_b), .pu_c(pu_c), .b7_out(b7_out), .b7_oe(b7_oe),
      .pad_c(pad_c), .pin_a(pin_a), .pin_b(pin_b), .pin_c(pin_c));

   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk

   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
      end while (!pready);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb

   task results;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errors++;
         results();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge pclk);
      chk(pu_a, 8'hFF);
      presetn <= 1; ext_a <= 8'hA5; ext_b <= 8'h3C; ext_c <= 8'h69; ctl_b.pullup_en <= 8'h5A;
      ctl_c.pullup_en <= 8'hC3;
      repeat (4) @(posedge pclk);
      chk(pu_b, 8'h5A);
      chk(pu_c, 8'hC3);
      apb(0, AD_B, 0); chk(rd, 8'h3C);
      chk(b7_out, 0);
      for (int m = 0; m < 4; m++) begin
         ctl_a.fsel <= {8{m[1:0]}}; ctl_b.fsel <= {8{m[1:0]}};
         apb(1, AD_A, 32'h0000_00FF); apb(1, AD_B, 32'h0000_00FF);
         apb(0, AD_A, 0); chk(rd, m[1] ? 8'hA5 : 8'h00);
         apb(0, AD_B, 0); chk(rd, m[1] ? 8'h3C : 8'h80);
         chk(b7_oe, m == 1);
         chk(pin_b[7], m == 1);
      end
      drv <= 0;
      repeat (4) @(posedge pclk);
      apb(0, AD_A, 0); chk(rd, 8'hFF);
      drv <= 1; ctl_b.fsel <= 16'h0000;
      apb(0, AD_C, 0); chk(rd, 8'h00);
      apb(1, AD_C, 32'h0000_0096); apb(0, AD_C, 0); chk(rd, 8'h96);
      pstrb <= 4'h0;
      apb(1, AD_C, 32'h0000_0011);
      pstrb <= 4'h1;
      apb(0, AD_C, 0); chk(rd, 8'h96);
      apb(0, AD_B, 0); chk(rd, 8'h80);
      ctl_c.fsel <= 16'h5555;
      repeat (3) @(posedge pclk);
      chk(pin_c, 8'h96);
      ctl_c.fsel <= 16'hAAAA;
      repeat (3) @(posedge pclk);
      apb(0, AD_C, 0); chk(rd, 8'h69);
      apb(0, 32'h1000_04B0, 0); chk(rd, 8'hA5);
      apb(0, 32'h1000_04B4, 0); chk(er, 1);
      chk(rd, 32'h0000_0000);
      apb(1, 32'h1000_04B4, 32'h0000_00FF); chk(er, 1);
      apb(0, AD_A + 1, 0); chk(er, 1);
      presetn <= 0;
      repeat (2) @(posedge pclk);
      chk(b7_out, 0);
      presetn <= 1;
      apb(0, AD_B, 0); chk(rd, 8'h00);
      results();
   end
endmodule : tb_top
